/* File: design/aps_defines.svh */
// Register offsets, field positions and reset values for the alternate pin steering block.
`ifndef APS_DEFINES_SVH
`define APS_DEFINES_SVH
`define APS_ROUTE_B_ADDR 12'h000
`define APS_CONFIG_ADDR 12'h004
`define APS_RXDT_BIT 7
`define APS_SDO_BIT 6
`define APS_SS_BIT 5
`define APS_TGATE_BIT 3
`define APS_TXCK_BIT 2
`define APS_ROUTE_B_MASK 8'hec
`define APS_ROUTE_B_RESET 8'h00
`define APS_RDATA_RESET 32'h0000_0000
`endif

/* File: design/aps_pkg.sv */
// Types shared by the alternate pin steering block.
package aps_pkg;
    // Peripheral drive request for one function: output data and output enable.
    typedef struct packed {
        logic dout;
        logic oe;
    } aps_drive_t;
    // Pin-side view of one candidate pin: override flag, data and enable.
    typedef struct packed {
        logic ovr;
        logic dout;
        logic oe;
    } aps_pin_t;
endpackage

/* File: design/aps_steer.sv */
// Alternate pin steering with an APB register slave.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "aps_defines.svh"
// Summary of operation
// - Software selection bits steer each function; on large package select stays on pin A.
// - Receive, transmit, data out, select, gate move.
// - Selection changes never touch direction registers.
// - Overrides follow the currently selected pin.
// - Unselected pin keeps ordinary port behaviour.
module aps_steer (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic large_pkg,
    input wire aps_pkg::aps_drive_t rxdt_drv,
    input wire aps_pkg::aps_drive_t txck_drv,
    input wire aps_pkg::aps_drive_t sdo_drv,
    input wire logic rxdt_pin_a_in,
    input wire logic rxdt_pin_b_in,
    input wire logic ss_pin_a_in,
    input wire logic ss_pin_b_in,
    input wire logic tgate_pin_a_in,
    input wire logic tgate_pin_b_in,
    output aps_pkg::aps_pin_t rxdt_pin_a,
    output aps_pkg::aps_pin_t rxdt_pin_b,
    output aps_pkg::aps_pin_t txck_pin_a,
    output aps_pkg::aps_pin_t txck_pin_b,
    output aps_pkg::aps_pin_t sdo_pin_a,
    output aps_pkg::aps_pin_t sdo_pin_b,
    output logic rxdt_in,
    output logic slave_select_in,
    output logic timer_gate_input,
    output logic [7:0] route_sel_q
);
    logic [7:0] route_ff, nxt_route;
    logic [31:0] rdata_ff, nxt_rdata;
    logic ready_ff, nxt_ready, err_ff, nxt_err;
    logic [2:0] large_sync_ff;
    logic large_q_ff;
    logic nxt_large_q;
    aps_pkg::aps_pin_t rx_a_ff, rx_b_ff, tx_a_ff, tx_b_ff, so_a_ff, so_b_ff;
    aps_pkg::aps_pin_t nxt_rx_a, nxt_rx_b, nxt_tx_a, nxt_tx_b, nxt_so_a, nxt_so_b;
    logic rxin_ff, ssin_ff, tgin_ff, nxt_rxin, nxt_ssin, nxt_tgin;
    logic setup_cyc, addr_ok, route_wr;

    assign setup_cyc = psel && !penable;
    assign addr_ok = (paddr == `APS_ROUTE_B_ADDR) || (paddr == `APS_CONFIG_ADDR);
    // A write lands only at the access edge where the master sees pready high, never at setup.
    assign route_wr = psel && penable && ready_ff && pwrite && (paddr == `APS_ROUTE_B_ADDR);

    // Package strap crosses into the clock domain; a change counts once stages two and three agree.
    always_comb begin
        nxt_large_q = large_q_ff;
        if (large_sync_ff[1] == large_sync_ff[2]) begin
            nxt_large_q = large_sync_ff[2];
        end
    end

    // Slave answers one cycle after setup, so pready rises in the first access cycle.
    always_comb begin
        nxt_route = route_ff;
        nxt_rdata = rdata_ff;
        nxt_ready = 1'b0;
        nxt_err = 1'b0;
        if (setup_cyc) begin
            nxt_ready = 1'b1;
            nxt_err = !addr_ok;
            nxt_rdata = `APS_RDATA_RESET;
            if (!pwrite && paddr == `APS_ROUTE_B_ADDR) begin
                nxt_rdata = {24'h000000, route_ff};
            end else if (!pwrite && paddr == `APS_CONFIG_ADDR) begin
                nxt_rdata = {31'h00000000, large_q_ff};
            end
        end
        if (route_wr) begin
            nxt_route = pwdata[7:0] & `APS_ROUTE_B_MASK;
        end
        if (large_q_ff) begin
            nxt_route[`APS_SS_BIT] = 1'b0;
        end
    end

    // Each function drives only its selected pin; the other gets no override and keeps port control.
    always_comb begin
        nxt_rx_a = '{ovr: !route_ff[`APS_RXDT_BIT], dout: rxdt_drv.dout, oe: rxdt_drv.oe};
        nxt_rx_b = '{ovr: route_ff[`APS_RXDT_BIT], dout: rxdt_drv.dout, oe: rxdt_drv.oe};
        nxt_tx_a = '{ovr: !route_ff[`APS_TXCK_BIT], dout: txck_drv.dout, oe: txck_drv.oe};
        nxt_tx_b = '{ovr: route_ff[`APS_TXCK_BIT], dout: txck_drv.dout, oe: txck_drv.oe};
        nxt_so_a = '{ovr: !route_ff[`APS_SDO_BIT], dout: sdo_drv.dout, oe: sdo_drv.oe};
        nxt_so_b = '{ovr: route_ff[`APS_SDO_BIT], dout: sdo_drv.dout, oe: sdo_drv.oe};
        if (!nxt_rx_a.ovr) nxt_rx_a = '0;
        if (!nxt_rx_b.ovr) nxt_rx_b = '0;
        if (!nxt_tx_a.ovr) nxt_tx_a = '0;
        if (!nxt_tx_b.ovr) nxt_tx_b = '0;
        if (!nxt_so_a.ovr) nxt_so_a = '0;
        if (!nxt_so_b.ovr) nxt_so_b = '0;
        // Inputs arrive already synchronised by the port block, so a plain select is enough.
        nxt_rxin = route_ff[`APS_RXDT_BIT] ? rxdt_pin_b_in : rxdt_pin_a_in;
        nxt_ssin = route_ff[`APS_SS_BIT] ? ss_pin_b_in : ss_pin_a_in;
        nxt_tgin = route_ff[`APS_TGATE_BIT] ? tgate_pin_b_in : tgate_pin_a_in;
    end

    // Direction registers live in the port block and no path here writes them.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            route_ff <= `APS_ROUTE_B_RESET;
            rdata_ff <= `APS_RDATA_RESET;
            ready_ff <= 1'b0;
            err_ff <= 1'b0;
            large_sync_ff <= 3'h0;
            large_q_ff <= 1'b0;
            rx_a_ff <= '0;
            rx_b_ff <= '0;
            tx_a_ff <= '0;
            tx_b_ff <= '0;
            so_a_ff <= '0;
            so_b_ff <= '0;
            rxin_ff <= 1'b0;
            ssin_ff <= 1'b0;
            tgin_ff <= 1'b0;
        end else begin
            route_ff <= nxt_route;
            rdata_ff <= nxt_rdata;
            ready_ff <= nxt_ready;
            err_ff <= nxt_err;
            large_sync_ff <= {large_sync_ff[1:0], large_pkg};
            large_q_ff <= nxt_large_q;
            rx_a_ff <= nxt_rx_a;
            rx_b_ff <= nxt_rx_b;
            tx_a_ff <= nxt_tx_a;
            tx_b_ff <= nxt_tx_b;
            so_a_ff <= nxt_so_a;
            so_b_ff <= nxt_so_b;
            rxin_ff <= nxt_rxin;
            ssin_ff <= nxt_ssin;
            tgin_ff <= nxt_tgin;
        end
    end

    assign prdata = rdata_ff;
    assign pready = ready_ff;
    assign pslverr = err_ff;
    assign rxdt_pin_a = rx_a_ff;
    assign rxdt_pin_b = rx_b_ff;
    assign txck_pin_a = tx_a_ff;
    assign txck_pin_b = tx_b_ff;
    assign sdo_pin_a = so_a_ff;
    assign sdo_pin_b = so_b_ff;
    assign rxdt_in = rxin_ff;
    assign slave_select_in = ssin_ff;
    assign timer_gate_input = tgin_ff;
    assign route_sel_q = route_ff;

    property p_reserved_zero;
        @(posedge core_clk) disable iff (sys_rst) (route_ff & ~`APS_ROUTE_B_MASK) == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved select bit set");
    property p_write_lands;
        @(posedge core_clk) disable iff (sys_rst)
            (route_wr && !large_q_ff) |=> route_ff == ($past(pwdata[7:0]) & `APS_ROUTE_B_MASK);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("select write lost");
    property p_ss_locked;
        @(posedge core_clk) disable iff (sys_rst) large_q_ff |=> !route_ff[`APS_SS_BIT];
    endproperty
    a_ss_locked: assert property (p_ss_locked) else $error("select bit writable on large package");
    property p_sdo_follows;
        @(posedge core_clk) disable iff (sys_rst) 1'b1 |=> so_b_ff.ovr == $past(route_ff[`APS_SDO_BIT]);
    endproperty
    a_sdo_follows: assert property (p_sdo_follows) else $error("data out override on wrong pin");
    property p_exclusive;
        @(posedge core_clk) disable iff (sys_rst) !(rx_a_ff.ovr && rx_b_ff.ovr) && !(tx_a_ff.ovr && tx_b_ff.ovr);
    endproperty
    a_exclusive: assert property (p_exclusive) else $error("both pins overridden");
    property p_unsel_quiet;
        @(posedge core_clk) disable iff (sys_rst) !so_a_ff.ovr |-> !so_a_ff.oe && !so_a_ff.dout;
    endproperty
    a_unsel_quiet: assert property (p_unsel_quiet) else $error("unselected pin driven");
    property p_rx_in_route;
        @(posedge core_clk) disable iff (sys_rst) 1'b1 |=> rxin_ff == ($past(route_ff[`APS_RXDT_BIT]) ?
            $past(rxdt_pin_b_in) : $past(rxdt_pin_a_in));
    endproperty
    a_rx_in_route: assert property (p_rx_in_route) else $error("receive input misrouted");
    property p_ready_pulse;
        @(posedge core_clk) disable iff (sys_rst) setup_cyc |=> pready ##1 !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready not one cycle");
    property p_read_only_no_change;
        @(posedge core_clk) disable iff (sys_rst) !route_wr && !large_q_ff |=> $stable(route_ff);
    endproperty
    a_read_only_no_change: assert property (p_read_only_no_change) else $error("select changed w/o write");
    c_write: cover property (@(posedge core_clk) setup_cyc && pwrite && paddr == `APS_ROUTE_B_ADDR);
    c_alt_sdo: cover property (@(posedge core_clk) so_b_ff.ovr && so_b_ff.oe);
    c_bad_addr: cover property (@(posedge core_clk) pslverr);
    c_large_lock: cover property (@(posedge core_clk) large_q_ff && route_wr && pwdata[`APS_SS_BIT]);
    c_alt_rx: cover property (@(posedge core_clk) rx_b_ff.ovr && rx_b_ff.oe);
    property p_unmapped_err;
        @(posedge core_clk) disable iff (sys_rst) (setup_cyc && !addr_ok) |=> pslverr && pready;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused");
    property p_err_with_ready;
        @(posedge core_clk) disable iff (sys_rst) pslverr |-> pready;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
    property p_tgate_route;
        @(posedge core_clk) disable iff (sys_rst) 1'b1 |=> tgin_ff == ($past(route_ff[`APS_TGATE_BIT]) ?
            $past(tgate_pin_b_in) : $past(tgate_pin_a_in));
    endproperty
    a_tgate_route: assert property (p_tgate_route) else $error("timer gate input misrouted");
    property p_ss_route;
        @(posedge core_clk) disable iff (sys_rst) 1'b1 |=> ssin_ff == ($past(route_ff[`APS_SS_BIT]) ?
            $past(ss_pin_b_in) : $past(ss_pin_a_in));
    endproperty
    a_ss_route: assert property (p_ss_route) else $error("slave select input misrouted");
endmodule
`default_nettype wire

/* File: dv/aps_periph_model.sv */
// Behavioural peripherals and port pins facing the steering block.
`timescale 1ns/1ps
`default_nettype none
module aps_periph_model (
    input wire logic core_clk,
    input wire logic [11:0] stim,
    output aps_pkg::aps_drive_t rxdt_drv,
    output aps_pkg::aps_drive_t txck_drv,
    output aps_pkg::aps_drive_t sdo_drv,
    output logic [5:0] pin_lvl
);
    // Levels move just after the edge, as real peripherals and pins would.
    always_ff @(posedge core_clk) begin
        {rxdt_drv, txck_drv, sdo_drv, pin_lvl} <= stim;
    end
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench for the alternate pin steering block.
`timescale 1ns/1ps
`default_nettype none
`include "aps_defines.svh"
module tb;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, large_pkg = 1'b0;
    logic [11:0] paddr = 12'h000, stim = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd, wv;
    logic pready, pslverr, err, rxdt_in, slave_select_in, timer_gate_input;
    logic [7:0] route_sel_q, rt;
    logic [5:0] pin_lvl;
    aps_pkg::aps_drive_t rxdt_drv, txck_drv, sdo_drv;
    aps_pkg::aps_pin_t rxdt_pin_a, rxdt_pin_b, txck_pin_a, txck_pin_b, sdo_pin_a, sdo_pin_b;
    int miscompares = 0;
    int n_tests = 0;
    always #50 core_clk = ~core_clk;
    aps_periph_model peer_u (.core_clk, .stim, .rxdt_drv, .txck_drv, .sdo_drv, .pin_lvl);
    aps_steer dut_u (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .large_pkg, .rxdt_drv, .txck_drv, .sdo_drv, .rxdt_pin_a_in(pin_lvl[0]),
        .rxdt_pin_b_in(pin_lvl[1]), .ss_pin_a_in(pin_lvl[2]), .ss_pin_b_in(pin_lvl[3]),
        .tgate_pin_a_in(pin_lvl[4]), .tgate_pin_b_in(pin_lvl[5]), .rxdt_pin_a, .rxdt_pin_b,
        .txck_pin_a, .txck_pin_b, .sdo_pin_a, .sdo_pin_b, .rxdt_in, .slave_select_in,
        .timer_gate_input, .route_sel_q);
    function automatic aps_pkg::aps_pin_t pin_exp(input logic own, input aps_pkg::aps_drive_t d);
        pin_exp = own ? {1'b1, d.dout, d.oe} : 3'h0;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // The request is held until pready is sampled high; read data is taken at that edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk({31'h0, n < 20}, 32'h1);
    endtask
    initial begin
        void'($urandom(49));
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        apb(1'b0, `APS_ROUTE_B_ADDR, 32'h0);
        chk(rd, 32'h0);
        $display("test reset value done");
        for (int i = 0; i < 30; i++) begin
            large_pkg <= (i < 2) ? i[0] : 1'($urandom);
            stim <= 12'($urandom);
            wv = (i < 2) ? 32'hff : $urandom;
            repeat (4) @(posedge core_clk);
            apb(1'b1, `APS_ROUTE_B_ADDR, wv);
            chk({31'h0, err}, 32'h0);
            rt = wv[7:0] & 8'hec & (large_pkg ? 8'hdf : 8'hff);
            apb(1'b0, `APS_ROUTE_B_ADDR, 32'h0);
            chk(rd, {24'h0, rt});
            chk({24'h0, route_sel_q}, {24'h0, rt});
            apb(1'b0, `APS_CONFIG_ADDR, 32'h0);
            chk(rd, {31'h0, large_pkg});
            repeat (2) @(posedge core_clk);
            chk(32'({rxdt_pin_a, rxdt_pin_b, txck_pin_a, txck_pin_b, sdo_pin_a, sdo_pin_b}),
                32'({pin_exp(!rt[7], rxdt_drv), pin_exp(rt[7], rxdt_drv), pin_exp(!rt[2], txck_drv),
                pin_exp(rt[2], txck_drv), pin_exp(!rt[6], sdo_drv), pin_exp(rt[6], sdo_drv)}));
            chk({29'h0, rxdt_in, slave_select_in, timer_gate_input}, {29'h0, pin_lvl[3'(rt[7])],
                pin_lvl[3'(rt[5]) + 3'd2], pin_lvl[3'(rt[3]) + 3'd4]});
            $display("test route %0d done", i);
        end
        apb(1'b1, 12'h008, 32'hff);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b0, `APS_ROUTE_B_ADDR, 32'h0);
        chk(rd, {24'h0, rt});
        $display("test unmapped done");
        // A reset in mid-run must bring the selection register back to its reset value.
        sys_rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        apb(1'b0, `APS_ROUTE_B_ADDR, 32'h0);
        chk(rd, 32'h0);
        chk({24'h0, route_sel_q}, 32'h0);
        $display("test mid-run reset done");
        finish_test();
    end
    initial begin
        // Each pass needs about fifteen cycles; about twelve times the whole run is allowed.
        #(30 * 200 * 100);
        miscompares++;
        finish_test();
    end
endmodule
`default_nettype wire
